// [pgit_pkg.sv]
/*
 Package of the power gating interval timer: state types, carriers,
 timing constants and reset values.
 Assumes one 100 MHz clock and an external converter giving the interval in ms.
*/
// Behaviour
// R01: Timer mode repeats gate-low once per interval
// R02: One-shot mode pulses once after power-up
// R03: Gate-low lasts interval minus 50 ms
// R04: Gate high for last 50 ms
// R05: Gate defaults high during resistor reading
// R06: Gate goes low at interval start
// R07: Only rising completion edge counts
// R08: First completion per interval acts, rest ignored
// R09: Host holds completion at least 100 ns
// R10: Completion during gate-low ends pulse early
// R11: Measure once, then enter strapped mode
// R12: Mode strap is hard wired
// R13: One-shot manual on gives one pulse
// R14: Manual request ignored while gate low
// R15: Manual during reading aborts, restarts on release
// R16: Manual valid after 20 ms high
// R17: Manual input debounced on both edges
// R18: Gate low within 10 ms of manual
// R19: Manual clears counters, resumes on release
// R20: Manual held keeps gate low, ignores completion
// R21: Falling edge spacing equals programmed interval
// R22: After reading, pin high means manual request
// R23: Conversion takes at most 120 ms
// R24: Interval code counted with millisecond tick
package pgit_pkg;
    localparam int IVL_W = 23;
    localparam int TICK_W = 24;
    localparam int DB_W = 6;
    localparam int CONV_W = 8;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_TIME_NS = 1000000;
    localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
    localparam int DONE_MIN_NS = 100;
    localparam int DONE_MIN_CYCLES = (DONE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [IVL_W-1:0] GATE_OFF_TAIL_MS = 23'h000032;
    localparam logic [IVL_W-1:0] INTERVAL_MIN_MS = 23'h000064;
    localparam logic [IVL_W-1:0] INTERVAL_MAX_MS = 23'h6ddd00;
    localparam logic [DB_W-1:0] MANUAL_ON_MIN_HOLD_MS = 6'h14;
    localparam logic [DB_W-1:0] MANUAL_ON_OBS_MS = 6'h1e;
    localparam logic [DB_W-1:0] MANUAL_ON_DELAY_MS = 6'h0a;
    localparam logic [CONV_W-1:0] CONV_TYP_MS = 8'h64;
    localparam logic [CONV_W-1:0] CONV_MAX_MS = 8'h78;
    localparam logic RST_GATE_N = 1'b1;
    localparam logic RST_CONV_EN = 1'b1;

    typedef enum logic [2:0] {
        ST_MEASURE,
        ST_ABORT,
        ST_ON,
        ST_TAIL,
        ST_IDLE,
        ST_MANUAL
    } pgit_state_t;

    typedef struct packed {
        logic valid;
        logic [IVL_W-1:0] interval_ms;
    } pgit_conv_t;

    typedef struct packed {
        logic gate_drive_n;
        logic conv_enable;
        logic timer_mode;
        logic manual_active;
    } pgit_status_t;

    typedef struct packed {
        logic stable;
        logic [DB_W-1:0] cnt;
    } pgit_db_t;
endpackage

// [pgit_debounce.sv]
/*
 Debouncer of the manual power-on level, both edges.
 Assumes a synchronised input and a one-cycle millisecond tick on clk.
*/
`timescale 1ns/1ns
module pgit_debounce #(
    parameter logic [pgit_pkg::DB_W-1:0] HOLD_MS = pgit_pkg::MANUAL_ON_MIN_HOLD_MS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Timing
    input wire logic ms_tick,
    // Level
    input wire logic level_in,
    output logic level_out
);
    pgit_pkg::pgit_db_t r;
    pgit_pkg::pgit_db_t next_r;

    // A change must hold HOLD_MS whole ticks, so a level is judged well inside 30 ms
    always_comb begin
        next_r = r;
        if (level_in == r.stable) begin
            next_r.cnt = '0; // R17
        end else if (ms_tick) begin
            if (r.cnt + 1'b1 >= HOLD_MS) begin
                next_r.stable = level_in; // R16
                next_r.cnt = '0;
            end else begin
                next_r.cnt = r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level_out = r.stable;
endmodule

// [pgit_core.sv]
/*
 Power gating interval timer core: start-up reading sequence, interval
 counting, gate drive, completion handling and manual power-on.
 Assumes an external analog converter that reports the interval in ms,
 and asynchronous pins for strap, completion and the shared manual pin.
*/
`timescale 1ns/1ns
module pgit_core #(
    parameter int MS_CYCLES = pgit_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins from the board
    input wire logic mode_strap,
    input wire logic done_pin,
    input wire logic interval_resistor_manual_on_pin,
    // Analog converter
    input wire pgit_pkg::pgit_conv_t conv,
    // Outputs
    output logic gate_drive_n,
    output logic conv_enable,
    output logic timer_mode,
    output logic manual_active
);
    typedef struct packed {
        pgit_pkg::pgit_state_t st;
        logic [pgit_pkg::IVL_W-1:0] interval;
        logic [pgit_pkg::IVL_W-1:0] ms_count;
        logic [pgit_pkg::TICK_W-1:0] tick_div;
        logic tick;
        logic [pgit_pkg::CONV_W-1:0] conv_ms;
        logic [1:0] done_sync;
        logic done_prev;
        logic [1:0] strap_sync;
        logic [1:0] man_sync;
        logic [1:0] warm;
        logic done_armed;
        pgit_pkg::pgit_status_t out;
    } pgit_core_t;

    localparam logic [pgit_pkg::TICK_W-1:0] TICK_LAST = pgit_pkg::TICK_W'(MS_CYCLES - 1);

    pgit_core_t r;
    pgit_core_t next_r;
    logic manual_level;
    logic done_rise;
    logic [pgit_pkg::IVL_W-1:0] on_limit;
    logic [pgit_pkg::IVL_W-1:0] ivl_last;
    logic ivl_end;
    logic [pgit_pkg::IVL_W-1:0] code;

    // Debounced manual request; the reading path uses the raw synced level
    pgit_debounce #(
        .HOLD_MS(pgit_pkg::MANUAL_ON_MIN_HOLD_MS)
    ) u_debounce (
        .clk(clk),
        .rst(rst),
        .ms_tick(r.tick),
        .level_in(r.man_sync[1]),
        .level_out(manual_level)
    );

    always_comb begin
        // Edge seen only on the second synchroniser stage
        done_rise = r.done_sync[1] & ~r.done_prev; // R07
        on_limit = r.interval - pgit_pkg::GATE_OFF_TAIL_MS; // R03
        ivl_last = r.interval - 1'b1;
        ivl_end = r.tick && (r.ms_count >= ivl_last);
        // Out-of-range codes are clamped rather than trusted
        if (conv.interval_ms < pgit_pkg::INTERVAL_MIN_MS) begin
            code = pgit_pkg::INTERVAL_MIN_MS;
        end else if (conv.interval_ms > pgit_pkg::INTERVAL_MAX_MS) begin
            code = pgit_pkg::INTERVAL_MAX_MS;
        end else begin
            code = conv.interval_ms;
        end
    end

    always_comb begin
        next_r = r;
        next_r.done_sync = {r.done_sync[0], done_pin};
        next_r.done_prev = r.done_sync[1];
        next_r.strap_sync = {r.strap_sync[0], mode_strap};
        next_r.man_sync = {r.man_sync[0], interval_resistor_manual_on_pin};
        next_r.warm = {r.warm[0], 1'b1};

        // Millisecond tick from the free-running oscillator clock
        if (r.tick_div >= TICK_LAST) begin
            next_r.tick_div = '0;
            next_r.tick = 1'b1; // R24
        end else begin
            next_r.tick_div = r.tick_div + 1'b1;
            next_r.tick = 1'b0;
        end

        unique case (r.st)
            pgit_pkg::ST_MEASURE: begin
                next_r.out.conv_enable = 1'b1;
                next_r.out.gate_drive_n = 1'b1;
                if (r.tick) begin
                    next_r.conv_ms = r.conv_ms + 1'b1;
                end
                if (!r.warm[1]) begin
                    // Synchronisers still hold reset zeros, so strap and pin are not trusted yet
                    next_r.st = pgit_pkg::ST_MEASURE;
                end else if (r.man_sync[1]) begin
                    // Reading is thrown away and redone later
                    next_r.st = pgit_pkg::ST_ABORT; // R15
                    next_r.out.conv_enable = 1'b0;
                end else if (conv.valid) begin
                    // The only place the interval and the mode are taken
                    next_r.interval = code; // R11
                    next_r.out.timer_mode = r.strap_sync[1]; // R11
                    next_r.out.conv_enable = 1'b0; // R22
                    next_r.out.gate_drive_n = 1'b0; // R06
                    next_r.ms_count = '0;
                    next_r.done_armed = 1'b1;
                    next_r.st = pgit_pkg::ST_ON; // R02
                end else if (r.conv_ms >= pgit_pkg::CONV_MAX_MS) begin
                    // A hung converter is retried through the abort path
                    next_r.st = pgit_pkg::ST_ABORT; // R23
                    next_r.out.conv_enable = 1'b0;
                end
            end
            pgit_pkg::ST_ABORT: begin
                next_r.out.conv_enable = 1'b0;
                next_r.out.gate_drive_n = 1'b1;
                next_r.conv_ms = '0;
                if (!r.man_sync[1]) begin
                    next_r.st = pgit_pkg::ST_MEASURE; // R15
                    next_r.out.conv_enable = 1'b1;
                end
            end
            pgit_pkg::ST_ON: begin
                if (r.tick) begin
                    next_r.ms_count = r.ms_count + 1'b1; // R24
                end
                if (done_rise && r.done_armed) begin
                    // Only the first edge of an interval is honoured
                    next_r.done_armed = 1'b0; // R08
                    next_r.out.gate_drive_n = 1'b1; // R10
                    next_r.st = r.out.timer_mode ? pgit_pkg::ST_TAIL : pgit_pkg::ST_IDLE;
                end else if (r.tick && (r.ms_count + 1'b1 >= on_limit)) begin
                    next_r.out.gate_drive_n = 1'b1; // R04
                    next_r.st = r.out.timer_mode ? pgit_pkg::ST_TAIL : pgit_pkg::ST_IDLE; // R13
                end
                // Manual request ignored here since the gate is already low
            end
            pgit_pkg::ST_TAIL: begin
                if (done_rise) begin
                    next_r.done_armed = 1'b0; // R08
                end
                if (manual_level) begin // R14
                    next_r.st = pgit_pkg::ST_MANUAL; // R16
                    next_r.out.gate_drive_n = 1'b0; // R18
                    next_r.ms_count = '0; // R19
                end else if (ivl_end) begin
                    // Falling edges stay one interval apart
                    next_r.ms_count = '0; // R21
                    next_r.done_armed = 1'b1;
                    next_r.out.gate_drive_n = 1'b0; // R01
                    next_r.st = pgit_pkg::ST_ON; // R06
                end else if (r.tick) begin
                    next_r.ms_count = r.ms_count + 1'b1;
                end
            end
            pgit_pkg::ST_IDLE: begin
                // One-shot rest: counters stand still until a manual request
                next_r.ms_count = '0;
                if (manual_level) begin // R14
                    next_r.st = pgit_pkg::ST_MANUAL; // R13
                    next_r.out.gate_drive_n = 1'b0; // R18
                end
            end
            pgit_pkg::ST_MANUAL: begin
                // Counters held cleared while the request stands
                next_r.ms_count = '0; // R19
                next_r.out.gate_drive_n = 1'b0; // R20
                next_r.done_armed = 1'b1;
                if (!manual_level) begin
                    // Counting resumes on the debounced release
                    next_r.st = pgit_pkg::ST_ON; // R19
                end
                // Completion edges fall through unused here
            end
        endcase

        next_r.out.manual_active = (next_r.st == pgit_pkg::ST_MANUAL);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.st <= pgit_pkg::ST_MEASURE;
            r.out.gate_drive_n <= pgit_pkg::RST_GATE_N; // R05
            r.out.conv_enable <= pgit_pkg::RST_CONV_EN;
        end else begin
            r <= next_r;
        end
    end

    assign gate_drive_n = r.out.gate_drive_n;
    assign conv_enable = r.out.conv_enable;
    assign timer_mode = r.out.timer_mode;
    assign manual_active = r.out.manual_active;
endmodule

// [pgit_core_monitor.sv]
/*
 Assertion checker for pgit_core, bound to every instance.
 Assumes the converter code stays constant while a reading runs.
*/
`timescale 1ns/1ns
module pgit_core_monitor #(
    parameter int MS_CYCLES = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and converter
    input wire logic mode_strap,
    input wire logic done_pin,
    input wire logic interval_resistor_manual_on_pin,
    input wire pgit_pkg::pgit_conv_t conv,
    // Outputs
    input wire logic gate_drive_n,
    input wire logic conv_enable,
    input wire logic timer_mode,
    input wire logic manual_active
);
    int hi_cnt;
    int lo_cnt;
    int pin_cnt;
    int ivl;
    logic man;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Run lengths; bounds allow one tick of phase slip
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_cnt <= 0;
            lo_cnt <= 0;
            pin_cnt <= 0;
            man <= 1'b0;
        end else begin
            hi_cnt <= gate_drive_n ? hi_cnt + 1 : 0;
            lo_cnt <= gate_drive_n ? 0 : lo_cnt + 1;
            pin_cnt <= interval_resistor_manual_on_pin ? pin_cnt + 1 : 0;
            man <= gate_drive_n ? 1'b0 : (man | manual_active);
        end
    end
    always_ff @(posedge clk) begin
        if (conv_enable && conv.valid) begin
            ivl <= int'(conv.interval_ms);
        end
    end
    chk_read_gate_high: assert property (conv_enable |-> gate_drive_n)
        else $error("gate low while reading");
    // One extra cycle after reset while the synchronisers fill
    chk_read_ends: assert property ((!interval_resistor_manual_on_pin)[*3] ##0 (conv_enable && conv.valid)
        |-> ##[1:2] (!conv_enable && !gate_drive_n && timer_mode == mode_strap)) else $error("reading did not end");
    chk_read_abort: assert property (interval_resistor_manual_on_pin[*3] ##0 conv_enable |-> ##[1:2] !conv_enable)
        else $error("reading not aborted");
    chk_done_ends: assert property ($rose(done_pin) && !gate_drive_n && !manual_active
        |-> ##[1:4] (gate_drive_n || manual_active)) else $error("completion ignored");
    chk_manual_low: assert property (manual_active |-> !gate_drive_n)
        else $error("gate high during manual hold");
    chk_manual_from_high: assert property ($rose(manual_active) |-> $past(gate_drive_n))
        else $error("manual taken while gate low");
    chk_manual_hold: assert property ($rose(manual_active) |-> pin_cnt >= 19 * MS_CYCLES)
        else $error("manual accepted too early");
    chk_tail_len: assert property ($fell(gate_drive_n) && !manual_active && !$past(conv_enable)
        |-> hi_cnt >= 49 * MS_CYCLES) else $error("off tail too short");
    chk_low_len: assert property (!man && !manual_active |-> lo_cnt <= (ivl - 49) * MS_CYCLES)
        else $error("gate low too long");
endmodule
bind pgit_core pgit_core_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.clk(clk), .rst(rst),
    .mode_strap(mode_strap), .done_pin(done_pin), .conv(conv),
    .interval_resistor_manual_on_pin(interval_resistor_manual_on_pin),
    .gate_drive_n(gate_drive_n), .conv_enable(conv_enable),
    .timer_mode(timer_mode), .manual_active(manual_active));

// [pgit_host.sv]
/*
 Host model: answers each gate-low window with one completion pulse.
 Assumes a delay of zero means the host never answers.
*/
`timescale 1ns/1ns
module pgit_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Gate and setting
    input wire logic gate_drive_n,
    input wire logic [15:0] done_delay,
    // Completion
    output logic done_pin
);
    int cnt;
    int hold;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            hold <= 0;
        end else begin
            cnt <= gate_drive_n ? 0 : cnt + 1;
            if (!gate_drive_n && done_delay != 16'h0000 && cnt == int'(done_delay)) begin
                hold <= pgit_pkg::DONE_MIN_CYCLES;
            end else if (hold != 0) begin
                hold <= hold - 1;
            end
        end
    end
    // Full hold even if the gate rises first
    assign done_pin = hold != 0;
endmodule

// [pgit_core_tb_top.sv]
/*
 Testbench of pgit_core with a shortened millisecond tick.
 Assumes the host model in pgit_host.
*/
`timescale 1ns/1ns
module pgit_core_tb_top;
    localparam int MS = 10;
    localparam int IVL = 100;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mode_strap = 1'b1;
    logic pin = 1'b0;
    logic [15:0] done_dly = 16'h0000;
    pgit_pkg::pgit_conv_t conv = '{valid: 1'b1, interval_ms: pgit_pkg::INTERVAL_MIN_MS};
    logic done_pin, gate_drive_n, conv_enable, timer_mode, manual_active;
    int n_errors = 0;
    int comparisons = 0;
    int n;
    int m;
    always #5 clk = ~clk;
    pgit_core #(.MS_CYCLES(MS)) DUT (.clk(clk), .rst(rst), .mode_strap(mode_strap), .done_pin(done_pin),
        .interval_resistor_manual_on_pin(pin), .conv(conv), .gate_drive_n(gate_drive_n),
        .conv_enable(conv_enable), .timer_mode(timer_mode), .manual_active(manual_active));
    pgit_host u_host (.clk(clk), .rst(rst), .gate_drive_n(gate_drive_n), .done_delay(done_dly),
        .done_pin(done_pin));
    task automatic chk(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: %s", $time, what);
        end
    endtask
    task automatic chkr(input int got, input int lo, input int hi, input string what);
        comparisons++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("ERROR %0t: %s took %0d", $time, what, got);
        end
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Bounded wait for a gate level; sampled at negedge, away from the drive edge
    task automatic wait_gate(input logic v, output int cnt);
        cnt = 0;
        while (gate_drive_n !== v) begin
            @(negedge clk);
            cnt++;
            if (cnt > 3000) begin
                n_errors++;
                $display("ERROR %0t: gate wait timed out", $time);
                end_of_test();
            end
        end
    endtask
    task automatic hold_chk(input logic v, input int cyc);
        logic ok;
        ok = 1'b1;
        repeat (cyc) begin
            @(negedge clk);
            if (gate_drive_n !== v) ok = 1'b0;
        end
        chk(ok, 1'b1, "gate level not held");
    endtask
    task automatic do_reset(input logic strap, input logic p);
        @(posedge clk);
        rst <= 1'b1;
        mode_strap <= strap;
        pin <= p;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic t_timer;
        do_reset(1'b1, 1'b0);
        wait_gate(1'b0, n);
        chkr(n, 1, 4, "start");
        chk(conv_enable, 1'b0, "reading still on");
        chk(timer_mode, 1'b1, "mode");
        for (int i = 0; i < 2; i++) begin
            wait_gate(1'b1, n);
            chkr(n, (IVL - 51) * MS, (IVL - 49) * MS, "gate low");
            wait_gate(1'b0, m);
            chkr(m, 49 * MS, 51 * MS, "off tail");
            chkr(n + m, (IVL - 1) * MS, (IVL + 1) * MS, "period");
        end
        $display("timer test done");
    endtask
    task automatic t_done;
        @(posedge clk);
        done_dly <= 16'h0064;
        wait_gate(1'b1, n);
        chkr(n, 90, 110, "completion");
        @(posedge clk);
        done_dly <= 16'h0000;
        wait_gate(1'b0, m);
        chkr(n + m, (IVL - 1) * MS, (IVL + 1) * MS, "period");
        $display("completion test done");
    endtask
    task automatic t_abort;
        do_reset(1'b1, 1'b1);
        hold_chk(1'b1, 6);
        chk(conv_enable, 1'b0, "reading not aborted");
        @(posedge clk);
        pin <= 1'b0;
        wait_gate(1'b0, n);
        chkr(n, 1, 12, "reading restart");
        $display("abort test done");
    endtask
    task automatic t_oneshot;
        do_reset(1'b0, 1'b0);
        wait_gate(1'b0, n);
        chk(timer_mode, 1'b0, "mode");
        // Request made and dropped while the gate is low must leave no trace
        @(posedge clk);
        pin <= 1'b1;
        repeat (25 * MS) @(posedge clk);
        pin <= 1'b0;
        @(negedge clk);
        chk(manual_active, 1'b0, "manual taken while gate low");
        chk(gate_drive_n, 1'b0, "gate left low pulse");
        wait_gate(1'b1, n);
        hold_chk(1'b1, 2 * IVL * MS);
        @(posedge clk);
        pin <= 1'b1;
        repeat (5 * MS) @(posedge clk);
        pin <= 1'b0;
        hold_chk(1'b1, 30 * MS);
        @(posedge clk);
        pin <= 1'b1;
        wait_gate(1'b0, n);
        chkr(n, 19 * MS, 31 * MS, "manual on");
        chk(manual_active, 1'b1, "manual flag");
        @(posedge clk);
        done_dly <= 16'h0014;
        hold_chk(1'b0, 40 * MS);
        @(posedge clk);
        done_dly <= 16'h0000;
        pin <= 1'b0;
        wait_gate(1'b1, n);
        chkr(n, (IVL - 51) * MS, (IVL - 29) * MS, "manual pulse");
        hold_chk(1'b1, IVL * MS);
        $display("one-shot test done");
    endtask
    initial begin
        t_timer();
        t_done();
        t_abort();
        t_oneshot();
        end_of_test();
    end
endmodule
